// File: rtl/htmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module htmc_ctrl import htmc_pkg::*; #(
    parameter logic [7:0] IDENTITY_CODE = ID_CODE_DEFAULT,
    parameter int unsigned PERIOD_1HZ_CYC = RATE_1HZ_CYC,
    parameter int unsigned PERIOD_7HZ_CYC = RATE_7HZ_CYC,
    parameter int unsigned PERIOD_12HZ5_CYC = RATE_12HZ5_CYC
) (
    input wire logic clk_sys, // 100 MHz system clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic cs_n, // Serial chip select pin, active low
    input wire logic scl, // Serial clock pin, idle high
    input wire logic sda_in, // Serial data pin, input side
    output logic sda_out, // Serial data pin, output side
    output logic sda_oe, // Serial data pin drive enable
    input wire htmc_cal_t cal, // Factory calibration values
    input wire htmc_acq_t acq, // Result from the sensing front end
    output logic acq_start, // One-cycle start of an acquisition
    output logic analog_enable, // Front end powered
    output logic sample_available_flag // New results not yet read
);
    // Pin synchronisers
    logic [2:0] pins_s;
    htmc_sync #(.W(3), .INIT(3'b110)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .d({cs_n, scl, sda_in}),
        .q(pins_s)
    );

    logic cs_n_s, scl_s, sda_s;
    assign cs_n_s = pins_s[2];
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // Serial engine state
    logic scl_prev, next_scl_prev;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic in_data, next_in_data;
    logic rw, next_rw;
    logic [6:0] addr, next_addr;
    logic [7:0] shift_in, next_shift_in;
    logic [7:0] shift_out, next_shift_out;
    logic next_sda_out, next_sda_oe;

    logic scl_rise, scl_fall, byte_done, rd_load, wr_en;
    logic [7:0] byte_in, rd_value;
    logic [6:0] rd_addr;

    // Control, measurement and result state
    htmc_ctrl_t ctrl, next_ctrl;
    htmc_trig_t trig, next_trig;
    htmc_acq_state_t state, next_state;
    logic [RATE_CNT_W-1:0] rate_cnt, next_rate_cnt;
    logic shot, next_shot;
    logic next_acq_start, next_analog_enable;
    logic [15:0] hum, next_hum, temp, next_temp;
    logic next_sample_available;
    logic active, rate_tick, meas_done, go;
    int unsigned period_sel;

    // Edge and byte decode from the synchronised pins
    always_comb begin
        scl_rise = !cs_n_s && !scl_prev && scl_s;
        scl_fall = !cs_n_s && scl_prev && !scl_s;
        byte_in = {shift_in[6:0], sda_s};
        byte_done = scl_rise && (bit_cnt == 3'h7);
        rd_load = byte_done && !in_data && byte_in[XFER_DIR_BIT];
        rd_addr = byte_in[6:0];
        wr_en = byte_done && in_data && !rw;
    end

    // Serial engine: address byte then data byte, repeated while selected
    always_comb begin
        next_scl_prev = scl_s;
        next_bit_cnt = bit_cnt;
        next_in_data = in_data;
        next_rw = rw;
        next_addr = addr;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_sda_out = sda_out;
        next_sda_oe = sda_oe;
        if (cs_n_s) begin
            next_bit_cnt = 3'h0;
            next_in_data = 1'b0;
            next_sda_oe = 1'b0;
        end else if (scl_rise) begin
            next_shift_in = byte_in;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                next_in_data = !in_data;
                if (!in_data) begin
                    next_rw = byte_in[XFER_DIR_BIT];
                    next_addr = byte_in[6:0];
                    if (rd_load) begin
                        next_shift_out = rd_value;
                    end
                end
            end
        end else if (scl_fall) begin
            // Drive on the falling edge so the host samples a settled bit on rising
            if (in_data && rw) begin
                next_sda_oe = 1'b1;
                next_sda_out = shift_out[7];
                next_shift_out = {shift_out[6:0], 1'b0};
            end else begin
                next_sda_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_prev <= 1'b1;
            bit_cnt <= 3'h0;
            in_data <= 1'b0;
            rw <= 1'b0;
            addr <= 7'h00;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_prev <= next_scl_prev;
            bit_cnt <= next_bit_cnt;
            in_data <= next_in_data;
            rw <= next_rw;
            addr <= next_addr;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            sda_out <= next_sda_out;
            sda_oe <= next_sda_oe;
        end
    end

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_value = 8'h00;
        case (rd_addr)
            ADDR_ID: rd_value = IDENTITY_CODE;
            ADDR_CTRL: begin
                rd_value[CTRL_PD_BIT] = ctrl.power_down_bit;
                rd_value[CTRL_BDU_BIT] = ctrl.bdu;
                rd_value[CTRL_RATE_LSB +: 2] = ctrl.rate_select_field;
            end
            ADDR_TRIG: begin
                rd_value[TRIG_BOOT_BIT] = trig.boot;
                rd_value[TRIG_HEATER_BIT] = trig.heater;
                rd_value[TRIG_SHOT_BIT] = trig.oneshot;
            end
            ADDR_HUM_L: rd_value = hum[7:0];
            ADDR_HUM_H: rd_value = hum[15:8];
            ADDR_TEMP_L: rd_value = temp[7:0];
            ADDR_TEMP_H: rd_value = temp[15:8];
            ADDR_HP0: rd_value = cal.humidity_point0_doubled;
            ADDR_HP1: rd_value = cal.humidity_point1_doubled;
            ADDR_TP0_L: rd_value = cal.temperature_point0_eighths[7:0];
            ADDR_TP1_L: rd_value = cal.temperature_point1_eighths[7:0];
            ADDR_TP_UP: rd_value = {4'h0, cal.temperature_point1_eighths[9:8],
                cal.temperature_point0_eighths[9:8]};
            ADDR_HC0_L: rd_value = cal.humidity_point0_count[7:0];
            ADDR_HC0_H: rd_value = cal.humidity_point0_count[15:8];
            ADDR_HC1_L: rd_value = cal.humidity_point1_count[7:0];
            ADDR_HC1_H: rd_value = cal.humidity_point1_count[15:8];
            ADDR_TC0_L: rd_value = cal.temperature_point0_count[7:0];
            ADDR_TC0_H: rd_value = cal.temperature_point0_count[15:8];
            ADDR_TC1_L: rd_value = cal.temperature_point1_count[7:0];
            ADDR_TC1_H: rd_value = cal.temperature_point1_count[15:8];
            default: rd_value = 8'h00;
        endcase
    end

    // Control registers; a host write of the trigger wins over the self-clear
    always_comb begin
        next_ctrl = ctrl;
        next_trig = trig;
        if (meas_done && shot) begin
            next_trig.oneshot = 1'b0;
        end
        if (wr_en && addr == ADDR_CTRL) begin
            next_ctrl.power_down_bit = byte_in[CTRL_PD_BIT];
            next_ctrl.bdu = byte_in[CTRL_BDU_BIT];
            next_ctrl.rate_select_field = htmc_rate_t'(byte_in[CTRL_RATE_LSB +: 2]);
        end
        if (wr_en && addr == ADDR_TRIG) begin
            next_trig.boot = byte_in[TRIG_BOOT_BIT];
            next_trig.heater = byte_in[TRIG_HEATER_BIT];
            next_trig.oneshot = byte_in[TRIG_SHOT_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            trig <= TRIG_RESET;
        end else begin
            ctrl <= next_ctrl;
            trig <= next_trig;
        end
    end

    // Rate divider and acquisition sequencer
    always_comb begin
        active = ctrl.power_down_bit;
        case (ctrl.rate_select_field)
            RATE_1HZ: period_sel = PERIOD_1HZ_CYC;
            RATE_7HZ: period_sel = PERIOD_7HZ_CYC;
            RATE_12HZ5: period_sel = PERIOD_12HZ5_CYC;
            default: period_sel = 0;
        endcase
        next_rate_cnt = rate_cnt + 1'b1;
        rate_tick = 1'b0;
        if (!active || ctrl.rate_select_field == RATE_SINGLE) begin
            next_rate_cnt = '0;
        end else if (rate_cnt >= RATE_CNT_W'(period_sel - 1)) begin
            next_rate_cnt = '0;
            rate_tick = 1'b1;
        end
        // Restart on any control write, so a shorter new period never meets an overshot count
        if (wr_en && addr == ADDR_CTRL) begin
            next_rate_cnt = '0;
        end
        go = active && (rate_tick || (ctrl.rate_select_field == RATE_SINGLE && trig.oneshot));
        meas_done = (state == ACQ_WAIT) && active && acq.done;
        next_state = state;
        next_shot = shot;
        next_acq_start = 1'b0;
        next_analog_enable = active;
        case (state)
            ACQ_IDLE: begin
                if (go) begin
                    // A tick that lands during an acquisition is dropped, not queued
                    next_acq_start = 1'b1;
                    next_shot = !rate_tick;
                    next_state = ACQ_WAIT;
                end
            end
            ACQ_WAIT: begin
                if (!active || acq.done) begin
                    next_state = ACQ_IDLE;
                    next_shot = 1'b0;
                end
            end
            default: next_state = ACQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= ACQ_IDLE;
            rate_cnt <= '0;
            shot <= 1'b0;
            acq_start <= 1'b0;
            analog_enable <= 1'b0;
        end else begin
            state <= next_state;
            rate_cnt <= next_rate_cnt;
            shot <= next_shot;
            acq_start <= next_acq_start;
            analog_enable <= next_analog_enable;
        end
    end

    // Result capture; a new sample wins over a read in the same cycle
    always_comb begin
        next_hum = hum;
        next_temp = temp;
        next_sample_available = sample_available_flag;
        if (rd_load && rd_addr >= ADDR_HUM_L && rd_addr <= ADDR_TEMP_H) begin
            next_sample_available = 1'b0;
        end
        if (meas_done) begin
            next_hum = acq.humidity;
            next_temp = acq.temperature;
            next_sample_available = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hum <= RESULT_RESET;
            temp <= RESULT_RESET;
            sample_available_flag <= 1'b0;
        end else begin
            hum <= next_hum;
            temp <= next_temp;
            sample_available_flag <= next_sample_available;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // Trigger handshake in two steps: request seen, then a single start pulse
    sequence seq_shot_req;
        state == ACQ_IDLE && active && ctrl.rate_select_field == RATE_SINGLE && trig.oneshot;
    endsequence
    sequence seq_start_then_wait;
        (acq_start && state == ACQ_WAIT) ##1 !acq_start;
    endsequence

    AST_ID_READ: assert property (rd_load && rd_addr == ADDR_ID |=> shift_out == IDENTITY_CODE)
        else $error("identity read loaded wrong value");
    AST_NO_START_POWERED_DOWN: assert property (!active |=> !acq_start)
        else $error("acquisition started while powered down");
    AST_START_NEEDS_ACTIVE: assert property (acq_start |-> $past(active) && $past(state) == ACQ_IDLE)
        else $error("start without active idle state");
    AST_RATE_TICK: assert property (rate_tick |-> rate_cnt == RATE_CNT_W'(period_sel - 1)
        && ctrl.rate_select_field != RATE_SINGLE)
        else $error("rate tick at wrong count");
    AST_TICK_STARTS: assert property (rate_tick && state == ACQ_IDLE |=> acq_start)
        else $error("continuous tick did not start acquisition");
    AST_SHOT_START: assert property (seq_shot_req |=> seq_start_then_wait)
        else $error("trigger did not start one acquisition");
    AST_SHOT_CLEAR: assert property (meas_done && shot && !(wr_en && addr == ADDR_TRIG)
        |=> !trig.oneshot)
        else $error("trigger bit not cleared after acquisition");
    AST_HUM_CAPTURE: assert property (meas_done |=> hum == $past(acq.humidity)
        && sample_available_flag)
        else $error("humidity result not captured");
    AST_TEMP_CAPTURE: assert property (meas_done |=> temp == $past(acq.temperature))
        else $error("temperature result not captured");
    AST_UPPER_BITS: assert property (rd_load && rd_addr == ADDR_TP_UP |=> shift_out[3:0] ==
        {$past(cal.temperature_point1_eighths[9:8]), $past(cal.temperature_point0_eighths[9:8])})
        else $error("temperature upper bits misplaced");
    AST_READ_DIR: assert property (byte_done && !in_data |=> rw == $past(byte_in[XFER_DIR_BIT])
        && in_data)
        else $error("direction bit not taken from address byte");
    AST_HOLD_POWERED_DOWN: assert property (!active ##1 !active |-> $stable(hum) && $stable(temp))
        else $error("results changed while powered down");
endmodule
`default_nettype wire

// File: common/htmc_pkg.sv
// Functional notes
// - Reading address 0x0F always returns the fixed 8-bit identity code.
// - After reset the block is powered down, measurement logic off.
// - Mode comes from power-down bit, rate field at 0x20, trigger at 0x21.
// - Rate 00 single-shot, 01 1 Hz, 10 7 Hz, 11 12.5 Hz.
// - Continuous mode refreshes both results once per selected output period.
// - Writing 1 to the trigger bit starts one humidity and temperature acquisition when measuring at rate 00 (single-shot).
// - Trigger bit returns to 0 by itself when the triggered acquisition completes.
// - Raw humidity is 16-bit two's complement, low byte 0x28, high 0x29.
// - Raw temperature is 16-bit two's complement, low 0x2A, high 0x2B.
// - Humidity points at 0x30, 0x31 hold twice percent; host halves them.
// - Humidity point counts are signed words at 0x36/0x37 and 0x3A/0x3B.
// - Temperature points are 10-bit eighths; upper bits from 0x35; host divides.
// - Temperature point counts are signed words at 0x3C/0x3D and 0x3E/0x3F.
// - First transfer byte: direction bit on top, 1 read, 0 write, 7-bit address.
package htmc_pkg;

    // Register addresses, 7 bits wide on the serial port
    localparam logic [6:0] ADDR_ID = 7'h0F;
    localparam logic [6:0] ADDR_CTRL = 7'h20;
    localparam logic [6:0] ADDR_TRIG = 7'h21;
    localparam logic [6:0] ADDR_HUM_L = 7'h28;
    localparam logic [6:0] ADDR_HUM_H = 7'h29;
    localparam logic [6:0] ADDR_TEMP_L = 7'h2A;
    localparam logic [6:0] ADDR_TEMP_H = 7'h2B;
    localparam logic [6:0] ADDR_HP0 = 7'h30;
    localparam logic [6:0] ADDR_HP1 = 7'h31;
    localparam logic [6:0] ADDR_TP0_L = 7'h32;
    localparam logic [6:0] ADDR_TP1_L = 7'h33;
    localparam logic [6:0] ADDR_TP_UP = 7'h35;
    localparam logic [6:0] ADDR_HC0_L = 7'h36;
    localparam logic [6:0] ADDR_HC0_H = 7'h37;
    localparam logic [6:0] ADDR_HC1_L = 7'h3A;
    localparam logic [6:0] ADDR_HC1_H = 7'h3B;
    localparam logic [6:0] ADDR_TC0_L = 7'h3C;
    localparam logic [6:0] ADDR_TC0_H = 7'h3D;
    localparam logic [6:0] ADDR_TC1_L = 7'h3E;
    localparam logic [6:0] ADDR_TC1_H = 7'h3F;

    // Field positions
    localparam int CTRL_PD_BIT = 7;
    localparam int CTRL_BDU_BIT = 2;
    localparam int CTRL_RATE_LSB = 0;
    localparam int TRIG_BOOT_BIT = 7;
    localparam int TRIG_HEATER_BIT = 1;
    localparam int TRIG_SHOT_BIT = 0;
    localparam int XFER_DIR_BIT = 7;

    // Arbitrary neutral identity value, not tied to any real part
    localparam logic [7:0] ID_CODE_DEFAULT = 8'h5A;

    // Output rates in millihertz and the system clock
    localparam longint unsigned CLK_HZ = 64'd100000000;
    localparam longint unsigned RATE_1HZ_MHZ = 64'd1000;
    localparam longint unsigned RATE_7HZ_MHZ = 64'd7000;
    localparam longint unsigned RATE_12HZ5_MHZ = 64'd12500;
    localparam longint unsigned MHZ_PER_HZ = 64'd1000;
    // Period in cycles, rounded down
    localparam int unsigned RATE_1HZ_CYC = 32'(CLK_HZ * MHZ_PER_HZ / RATE_1HZ_MHZ);
    localparam int unsigned RATE_7HZ_CYC = 32'(CLK_HZ * MHZ_PER_HZ / RATE_7HZ_MHZ);
    localparam int unsigned RATE_12HZ5_CYC = 32'(CLK_HZ * MHZ_PER_HZ / RATE_12HZ5_MHZ);
    localparam int RATE_CNT_W = 27;

    typedef enum logic [1:0] {
        RATE_SINGLE = 2'b00,
        RATE_1HZ = 2'b01,
        RATE_7HZ = 2'b10,
        RATE_12HZ5 = 2'b11
    } htmc_rate_t;

    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_WAIT = 2'b01
    } htmc_acq_state_t;

    typedef struct packed {
        logic power_down_bit; // 1 = measuring, 0 = powered down
        logic bdu;
        htmc_rate_t rate_select_field;
    } htmc_ctrl_t;

    typedef struct packed {
        logic boot;
        logic heater;
        logic oneshot;
    } htmc_trig_t;

    typedef struct packed {
        logic [7:0] humidity_point0_doubled;
        logic [7:0] humidity_point1_doubled;
        logic [9:0] temperature_point0_eighths;
        logic [9:0] temperature_point1_eighths;
        logic [15:0] humidity_point0_count;
        logic [15:0] humidity_point1_count;
        logic [15:0] temperature_point0_count;
        logic [15:0] temperature_point1_count;
    } htmc_cal_t;

    typedef struct packed {
        logic done;
        logic [15:0] humidity;
        logic [15:0] temperature;
    } htmc_acq_t;

    localparam htmc_ctrl_t CTRL_RESET = '{power_down_bit: 1'b0, bdu: 1'b0, rate_select_field: RATE_SINGLE};
    localparam htmc_trig_t TRIG_RESET = '{boot: 1'b0, heater: 1'b0, oneshot: 1'b0};
    localparam logic [15:0] RESULT_RESET = 16'h0000;

endpackage

// File: rtl/htmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module htmc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [W-1:0] d, // Asynchronous inputs
    output logic [W-1:0] q // Synchronised outputs
);
    logic [W-1:0] meta;

    // Two stages; only the second stage is visible to logic
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// File: dv/htmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module htmc_host (
    input wire logic clk_sys, // System clock
    input wire logic sda, // Resolved data line
    output logic cs_n, // Chip select, active low
    output logic scl, // Serial clock, idle high
    output logic sda_drive, // Host data bit
    output logic sda_drive_en // Host drives the data line
);
    // Idle bus: deselected, clock high, line released
    initial begin
        cs_n = 1'b1;
        scl = 1'b1;
        sda_drive = 1'b0;
        sda_drive_en = 1'b0;
    end

    // Six cycles a level keeps clear of the synchroniser floor
    task automatic half();
        repeat (6) @(posedge clk_sys);
    endtask

    // One address byte then one data byte, MSB first, clock stands outside frames
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wd};
        rdata = 8'h00;
        cs_n <= 1'b0;
        half();
        for (int i = 15; i >= 0; i--) begin
            scl <= 1'b0;
            sda_drive_en <= !(rd && i < 8);
            sda_drive <= frame[i];
            half();
            scl <= 1'b1;
            half();
            if (i < 8) begin
                rdata[i] = sda;
            end
        end
        sda_drive_en <= 1'b0;
        cs_n <= 1'b1;
        half();
        half();
    endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import htmc_pkg::*;;
    localparam logic [7:0] ID_T = 8'hC3; // Arbitrary identity value
    localparam int P1 = 100;
    localparam int P7 = 70;
    localparam int P12 = 50;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cs_n, scl, h_drv, h_en, d_out, d_oe, sda_line, acq_start, analog_enable, flag;
    logic sda_float = 1'b0;
    htmc_cal_t cal = '0;
    htmc_acq_t acq = '0;
    int num_errors = 0, samples_checked = 0, cycles = 0, fe_cnt = 0, starts = 0, last_start = 0, last_gap = 0, s0;
    logic [31:0] seed = 32'h0001_0CA6;
    logic [15:0] m_hum = 16'h0000, m_tmp = 16'h0000;
    logic [7:0] m_ctrl = 8'h00, m_trig = 8'h00, rd;
    logic [127:0] cal_r;
    logic [7:0] img [128];
    int hum_rd, hum_exp, tmp_rd, tmp_exp;

    always #5 clk_sys = ~clk_sys;
    // Nobody drives: the line shows a changing pattern, not the last bit
    always @(posedge clk_sys) sda_float <= ~sda_float;
    assign sda_line = h_en ? h_drv : (d_oe ? d_out : sda_float);

    htmc_host i_host (.clk_sys(clk_sys), .sda(sda_line), .cs_n(cs_n), .scl(scl), .sda_drive(h_drv),
        .sda_drive_en(h_en));
    htmc_ctrl #(.IDENTITY_CODE(ID_T), .PERIOD_1HZ_CYC(P1), .PERIOD_7HZ_CYC(P7), .PERIOD_12HZ5_CYC(P12)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .scl(scl), .sda_in(sda_line), .sda_out(d_out),
        .sda_oe(d_oe), .cal(cal), .acq(acq), .acq_start(acq_start), .analog_enable(analog_enable),
        .sample_available_flag(flag));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Front end answers five cycles after a start; results captured alongside the design
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        acq.done <= 1'b0;
        if (acq.done) begin
            m_hum <= acq.humidity;
            m_tmp <= acq.temperature;
        end
        if (acq_start) begin
            fe_cnt <= 5;
            starts <= starts + 1;
            last_gap <= cycles - last_start;
            last_start <= cycles;
        end else if (fe_cnt == 1) begin
            fe_cnt <= 0;
            acq <= {1'b1, rnd()};
        end else if (fe_cnt > 0) begin
            fe_cnt <= fe_cnt - 1;
        end
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Host-side conversion: linear interpolation between two points, then scale down
    function automatic int interp(input int y0, input int y1, input int c0, input int c1, input int raw, input int dv);
        if (c1 == c0) return y0 / dv;
        return (y0 + (y1 - y0) * (raw - c0) / (c1 - c0)) / dv;
    endfunction

    // Humidity outside the sensing range is pinned to its bounds
    function automatic int clip_rh(input int v);
        return v < 0 ? 0 : (v > 100 ? 100 : v);
    endfunction

    // Register map as the host should see it
    function automatic logic [7:0] exp_reg(input logic [6:0] a);
        case (a)
            ADDR_ID: return ID_T;
            ADDR_CTRL: return m_ctrl & 8'h87;
            ADDR_TRIG: return m_trig & 8'h83;
            ADDR_HUM_L: return m_hum[7:0];
            ADDR_HUM_H: return m_hum[15:8];
            ADDR_TEMP_L: return m_tmp[7:0];
            ADDR_TEMP_H: return m_tmp[15:8];
            ADDR_HP0: return cal.humidity_point0_doubled;
            ADDR_HP1: return cal.humidity_point1_doubled;
            ADDR_TP0_L: return cal.temperature_point0_eighths[7:0];
            ADDR_TP1_L: return cal.temperature_point1_eighths[7:0];
            ADDR_TP_UP: return {4'h0, cal.temperature_point1_eighths[9:8], cal.temperature_point0_eighths[9:8]};
            ADDR_HC0_L: return cal.humidity_point0_count[7:0];
            ADDR_HC0_H: return cal.humidity_point0_count[15:8];
            ADDR_HC1_L: return cal.humidity_point1_count[7:0];
            ADDR_HC1_H: return cal.humidity_point1_count[15:8];
            ADDR_TC0_L: return cal.temperature_point0_count[7:0];
            ADDR_TC0_H: return cal.temperature_point0_count[15:8];
            ADDR_TC1_L: return cal.temperature_point1_count[7:0];
            ADDR_TC1_H: return cal.temperature_point1_count[15:8];
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer(1'b0, a, d, rd);
    endtask

    task automatic rchk(input logic [6:0] a);
        i_host.xfer(1'b1, a, 8'h00, rd);
        img[a] = rd;
        check($sformatf("reg %h", a), {8'h00, rd}, {8'h00, exp_reg(a)});
    endtask

    initial begin
        cal_r = {rnd(), rnd(), rnd(), rnd()};
        cal <= cal_r[99:0];
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("powered down", {14'h0000, analog_enable, flag}, 16'h0000);
        rchk(ADDR_ID);
        rchk(ADDR_CTRL);
        // Writes to read-only places must leave them alone
        wr(ADDR_ID, 8'hFF);
        wr(ADDR_HP0, ~exp_reg(ADDR_HP0));
        wr(ADDR_CTRL, 8'h84);
        m_ctrl = 8'h84;
        check("front end on", 16'(analog_enable), 16'h0001);
        wr(ADDR_TRIG, 8'h83);
        m_trig = 8'h83;
        for (int i = 0; i < 100 && flag !== 1'b1; i++) @(posedge clk_sys);
        m_trig = 8'h82;
        check("sample flag", 16'(flag), 16'h0001);
        rchk(ADDR_TRIG);
        // Sweep the whole map, unmapped holes included
        for (int a = 'h0F; a <= 'h3F; a++) rchk(7'(a));
        check("flag after read", 16'(flag), 16'h0000);
        // Conversions from the bytes read over the link, calibration taken from one sweep
        hum_rd = clip_rh(interp(img[7'h30], img[7'h31], $signed({img[7'h37], img[7'h36]}),
            $signed({img[7'h3B], img[7'h3A]}), $signed({img[7'h29], img[7'h28]}), 2));
        hum_exp = clip_rh(interp(cal.humidity_point0_doubled, cal.humidity_point1_doubled,
            $signed(cal.humidity_point0_count), $signed(cal.humidity_point1_count), $signed(m_hum), 2));
        tmp_rd = interp({img[7'h35][1:0], img[7'h32]}, {img[7'h35][3:2], img[7'h33]},
            $signed({img[7'h3D], img[7'h3C]}), $signed({img[7'h3F], img[7'h3E]}), $signed({img[7'h2B], img[7'h2A]}), 8);
        tmp_exp = interp(cal.temperature_point0_eighths, cal.temperature_point1_eighths,
            $signed(cal.temperature_point0_count), $signed(cal.temperature_point1_count), $signed(m_tmp), 8);
        check("humidity", 16'(hum_rd), 16'(hum_exp));
        check("temperature", 16'(tmp_rd), 16'(tmp_exp));
        // Each continuous rate: spacing of starts equals its period
        for (int r = 1; r <= 3; r++) begin
            wr(ADDR_CTRL, 8'h80 | 8'(r));
            repeat (400) @(posedge clk_sys);
            check("rate period", 16'(last_gap), 16'(r == 1 ? P1 : (r == 2 ? P7 : P12)));
        end
        wr(ADDR_CTRL, 8'h80);
        repeat (20) @(posedge clk_sys);
        rchk(ADDR_HUM_H);
        rchk(ADDR_TEMP_H);
        // Powered down: neither rate nor trigger may start anything
        wr(ADDR_CTRL, 8'h03);
        s0 = starts;
        repeat (200) @(posedge clk_sys);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_TRIG, 8'h01);
        m_ctrl = 8'h00;
        m_trig = 8'h01;
        repeat (200) @(posedge clk_sys);
        check("starts while down", 16'(starts - s0), 16'h0000);
        check("front end off", 16'(analog_enable), 16'h0000);
        rchk(ADDR_HUM_L);
        rchk(ADDR_TEMP_L);
        rchk(ADDR_TRIG);
        stop_test();
    end
endmodule
`default_nettype wire
